// ==== include/pecint_defines.vh ====
`ifndef PECINT_DEFINES_VH
`define PECINT_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PECINT_ADDR_RISE 8'h00
`define PECINT_ADDR_FALL 8'h04
`define PECINT_ADDR_FLAGS 8'h08
`define PECINT_ADDR_CTRL 8'h0C
`define PECINT_ADDR_IRQ_STAT 8'h10
`define PECINT_ADDR_IRQ_EN 8'h14
`define PECINT_ADDR_IRQ_CLR 8'h18

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PECINT_PINS 8
`define PECINT_CTRL_SUMMARY 0
`define PECINT_CTRL_MASTER 3
`define PECINT_IRQ_BITS 2
`define PECINT_EV_FLAG 0
`define PECINT_EV_WAKE 1

// ----------------------------------------
// Reset values and bus codes
// ----------------------------------------
`define PECINT_RESET8 8'h00
`define PECINT_RESET2 2'h0
`define PECINT_HTRANS_NONSEQ 2'h2
`define PECINT_HTRANS_SEQ 2'h3
`define PECINT_HSIZE_WORD 3'h2

`endif

// ==== core/pecint_sync.v ====
`timescale 1ns/1ps
`include "pecint_defines.vh"

module pecint_sync
(
	input wire hclk,
	input wire hresetn,
	input wire pin_in,
	output reg level_reg,
	output wire rise,
	output wire fall
);

reg s1_reg;
reg s2_reg;
reg s3_reg;

// ----------------------------------------
// Three stage sampler
// ----------------------------------------
// A change counts only once stages two and three agree, so the held level
// never follows a metastable first stage.
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		s1_reg <= 1'b0;
		s2_reg <= 1'b0;
		s3_reg <= 1'b0;
		level_reg <= 1'b0;
	end
	else
	begin
		s1_reg <= pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (s2_reg == s3_reg)
		begin
			level_reg <= s3_reg;
		end
	end
end

assign rise = (s2_reg == s3_reg) && s3_reg && !level_reg;
assign fall = (s2_reg == s3_reg) && !s3_reg && level_reg;

endmodule

// ==== core/pecint_core.v ====
`timescale 1ns/1ps
`include "pecint_defines.vh"

// Summary of operation
// - Each pin has a rising-edge detector enabled by its rise_detect_enable bit.
// - Each pin has a falling-edge detector enabled by its fall_detect_enable bit.
// - With both enable bits set a pin reports edges of either polarity.
// - An enabled edge sets the pin's change flag, which stays set until cleared.
// - The change interrupt is raised only while the master enable is one.
// - The summary flag is the OR of all eight pin change flags.
// - Writing zero to a pin change flag clears it.
// - An enabled edge in the same cycle as a clearing write leaves the flag set.
// - In sleep an enabled edge that sets a flag wakes the device if the master enable is one.
// - Edges seen in sleep are already in the flag register when wake is signalled.
// - Both edge enable registers are eight read-write bits reset to zero.
// - The flag register is eight bits, reset to zero, set by hardware, read-write.
// - A zero flag means no enabled change since the last clear.
// - With the master enable at zero, detection and flags still work but change_irq stays low.
module pecint_core
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [7:0] watched_port,
	input wire sleep_mode,
	output wire change_irq,
	output wire wake_request,
	output wire irq
);

reg [7:0] rise_detect_enable_reg;
reg [7:0] fall_detect_enable_reg;
reg [7:0] pin_change_flags_reg;
reg [7:0] pin_change_flags_next;
reg change_irq_master_enable_reg;
reg [1:0] irq_status_reg;
reg [1:0] irq_status_next;
reg [1:0] irq_enable_reg;
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg [31:0] rdata_next;
wire [7:0] pin_rise;
wire [7:0] pin_fall;
wire [7:0] edge_hit;
wire change_summary_flag;
wire addr_ok;
wire [1:0] irq_event;
wire [7:0] rd_addr;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// The held level stays inside each sampler; only its edge strobes are used.
// per pin sampling
genvar gi;
generate
	for (gi = 0; gi < `PECINT_PINS; gi = gi + 1)
	begin : g_pin
		pecint_sync u_sync
		(
			.hclk(hclk),
			.hresetn(hresetn),
			.pin_in(watched_port[gi]),
			.level_reg(),
			.rise(pin_rise[gi]),
			.fall(pin_fall[gi])
		);
	end
endgenerate

// ----------------------------------------
// Edge qualification
// ----------------------------------------
// rise and fall enable gate
assign edge_hit = (pin_rise & rise_detect_enable_reg) |
	(pin_fall & fall_detect_enable_reg);

// ----------------------------------------
// Bus slave
// ----------------------------------------
// Every access completes with no wait state; writes land one cycle after
// their address phase, which is when hwdata is valid.
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign addr_ok = hsel && hready &&
	(htrans == `PECINT_HTRANS_NONSEQ || htrans == `PECINT_HTRANS_SEQ);
assign rd_addr = haddr[7:0];

function is_addr;
	input [7:0] a;
	input [7:0] b;
	begin
		is_addr = (a == b);
	end
endfunction

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= `PECINT_RESET8;
	end
	else
	begin
		wr_pend_reg <= addr_ok && hwrite;
		wr_addr_reg <= haddr[7:0];
	end
end

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		rise_detect_enable_reg <= `PECINT_RESET8;
		fall_detect_enable_reg <= `PECINT_RESET8;
		change_irq_master_enable_reg <= 1'b0;
		irq_enable_reg <= `PECINT_RESET2;
	end
	else if (wr_pend_reg)
	begin
		if (is_addr(wr_addr_reg, `PECINT_ADDR_RISE))
		begin
			rise_detect_enable_reg <= hwdata[7:0];
		end
		else if (is_addr(wr_addr_reg, `PECINT_ADDR_FALL))
		begin
			fall_detect_enable_reg <= hwdata[7:0];
		end
		else if (is_addr(wr_addr_reg, `PECINT_ADDR_CTRL))
		begin
			change_irq_master_enable_reg <= hwdata[`PECINT_CTRL_MASTER];
		end
		else if (is_addr(wr_addr_reg, `PECINT_ADDR_IRQ_EN))
		begin
			irq_enable_reg <= hwdata[`PECINT_IRQ_BITS-1:0];
		end
	end
end

// ----------------------------------------
// Change flags
// ----------------------------------------
always @*
begin
	pin_change_flags_next = pin_change_flags_reg;
	if (wr_pend_reg && is_addr(wr_addr_reg, `PECINT_ADDR_FLAGS))
	begin
		pin_change_flags_next = hwdata[7:0];
	end
	pin_change_flags_next = pin_change_flags_next | edge_hit;
end

// flags run on the free clock, so sleep edges are captured at once
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		pin_change_flags_reg <= `PECINT_RESET8;
	end
	else
	begin
		pin_change_flags_reg <= pin_change_flags_next;
	end
end

assign change_summary_flag = |pin_change_flags_reg;

assign change_irq = change_summary_flag && change_irq_master_enable_reg;

assign wake_request = sleep_mode && change_irq;

// ----------------------------------------
// Sticky event status
// ----------------------------------------
assign irq_event[`PECINT_EV_FLAG] = |edge_hit;
assign irq_event[`PECINT_EV_WAKE] = sleep_mode && change_irq_master_enable_reg
	&& (|edge_hit);

always @*
begin
	irq_status_next = irq_status_reg;
	if (wr_pend_reg && is_addr(wr_addr_reg, `PECINT_ADDR_IRQ_CLR))
	begin
		irq_status_next = irq_status_reg & ~hwdata[`PECINT_IRQ_BITS-1:0];
	end
	// A new event in the clearing cycle is kept.
	irq_status_next = irq_status_next | irq_event;
end

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		irq_status_reg <= `PECINT_RESET2;
	end
	else
	begin
		irq_status_reg <= irq_status_next;
	end
end

assign irq = |(irq_status_reg & irq_enable_reg);

// ----------------------------------------
// Read data
// ----------------------------------------
// Read data is registered at the address phase from the next-state flags,
// so it shows the flags as they stand during the data phase.
always @*
begin
	rdata_next = 32'h00000000;
	if (is_addr(rd_addr, `PECINT_ADDR_RISE))
	begin
		rdata_next[7:0] = rise_detect_enable_reg;
	end
	else if (is_addr(rd_addr, `PECINT_ADDR_FALL))
	begin
		rdata_next[7:0] = fall_detect_enable_reg;
	end
	else if (is_addr(rd_addr, `PECINT_ADDR_FLAGS))
	begin
		rdata_next[7:0] = pin_change_flags_next;
	end
	else if (is_addr(rd_addr, `PECINT_ADDR_CTRL))
	begin
		rdata_next[`PECINT_CTRL_MASTER] = change_irq_master_enable_reg;
		rdata_next[`PECINT_CTRL_SUMMARY] = |pin_change_flags_next;
	end
	else if (is_addr(rd_addr, `PECINT_ADDR_IRQ_STAT))
	begin
		rdata_next[`PECINT_IRQ_BITS-1:0] = irq_status_next;
	end
	else if (is_addr(rd_addr, `PECINT_ADDR_IRQ_EN))
	begin
		rdata_next[`PECINT_IRQ_BITS-1:0] = irq_enable_reg;
	end
end

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		hrdata <= 32'h00000000;
	end
	else if (addr_ok && !hwrite)
	begin
		hrdata <= rdata_next;
	end
end

endmodule

// ==== dv/pecint_props.sv ====
`timescale 1ns/1ps
module pecint_props
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] watched_port,
	input wire sleep_mode,
	input wire change_irq,
	input wire wake_request,
	input wire irq
);
	// ----
	// Helpers
	// ----
	// Any write may move flags, so hold checks skip its update edge.
	reg wr_reg;
	wire take = hsel & hready & htrans[1];
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_reg <= 1'h0;
		else
			wr_reg <= take & hwrite;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_WAKE: assert property (wake_request == (sleep_mode && change_irq))
		else $error("wake level wrong");
	AST_FLAG_HOLD: assert property (change_irq && !wr_reg |=> change_irq)
		else $error("flag dropped without write");
	AST_IRQ_HOLD: assert property (irq && !wr_reg |=> irq)
		else $error("irq dropped without write");
	AST_EDGE_DELAY: assert property ($rose(change_irq) && !$past(wr_reg)
		|-> $past(watched_port, 4) != $past(watched_port, 5))
		else $error("flag rose off edge timing");
	AST_RESET_QUIET: assert property ($rose(hresetn) |-> !change_irq && !irq)
		else $error("outputs busy after reset");
	AST_READY: assert property (hreadyout)
		else $error("wait state seen");
	AST_OKAY: assert property (!hresp)
		else $error("error response seen");
	AST_RDATA_HOLD: assert property (!(take && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	cover property ($rose(change_irq));
	cover property (wake_request);
	cover property ($rose(irq));
endmodule

// ==== dv/pecint_pins.sv ====
`timescale 1ns/1ps
module pecint_pins
(
	input wire hclk,
	output reg [7:0] watched_port
);
	// ----
	// Pin driver
	// ----
	// Pins move just after an edge and then hold for many cycles.
	initial watched_port = 8'h00;
	task drive(input [7:0] v);
	begin
		@(posedge hclk);
		watched_port <= v;
	end
	endtask
endmodule

// ==== dv/pecint_bench.sv ====
`timescale 1ns/1ps
`include "pecint_defines.vh"
module pecint_bench;
	reg hclk = 1'h0;
	reg hresetn = 1'h0;
	reg hsel = 1'h0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'h0;
	reg [31:0] hwdata = 32'h0;
	reg sleep_mode = 1'h0;
	wire [31:0] hrdata;
	wire hreadyout;
	wire hresp;
	wire change_irq;
	wire wake_request;
	wire irq;
	wire [7:0] watched_port;
	integer failures = 0;
	integer checked = 0;
	integer cyc = 0;
	reg [31:0] q;
	reg [31:0] seen;
	always #50 hclk = ~hclk;
	pecint_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(`PECINT_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.watched_port(watched_port), .sleep_mode(sleep_mode),
		.change_irq(change_irq), .wake_request(wake_request), .irq(irq));
	pecint_pins pins (.hclk(hclk), .watched_port(watched_port));
	// ----
	// Tasks
	// ----
	task wrap_up;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task chk(input string n, input [31:0] e, input [31:0] s);
	begin
		checked = checked + 1;
		if (s !== e)
		begin
			failures = failures + 1;
			$display("mismatch %0s exp %h got %h", n, e, s);
		end
	end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= `PECINT_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		q = hrdata;
	end
	endtask
	task rc(input [7:0] a, input [31:0] e);
	begin
		xfer(1'h0, a, 32'h0);
		chk("hrdata", e, q);
	end
	endtask
	task t_reset;
	integer a;
	begin
		for (a = 0; a <= 28; a = a + 4)
			rc(a[7:0], 32'h0);
		$display("t_reset end");
	end
	endtask
	task t_edges;
	begin
		xfer(1'h1, `PECINT_ADDR_RISE, 32'h5);
		xfer(1'h1, `PECINT_ADDR_FALL, 32'h6);
		rc(`PECINT_ADDR_RISE, 32'h5);
		rc(`PECINT_ADDR_FALL, 32'h6);
		pins.drive(8'h07);
		repeat (5) @(posedge hclk);
		rc(`PECINT_ADDR_FLAGS, 32'h5);
		#1 chk("change_irq", 32'h0, {31'h0, change_irq});
		rc(`PECINT_ADDR_CTRL, 32'h1);
		xfer(1'h1, `PECINT_ADDR_FLAGS, 32'h0);
		rc(`PECINT_ADDR_FLAGS, 32'h0);
		pins.drive(8'h00);
		repeat (5) @(posedge hclk);
		rc(`PECINT_ADDR_FLAGS, 32'h6);
		$display("t_edges end");
	end
	endtask
	task t_master;
	begin
		xfer(1'h1, `PECINT_ADDR_CTRL, 32'h8);
		#1 chk("change_irq", 32'h1, {31'h0, change_irq});
		rc(`PECINT_ADDR_CTRL, 32'h9);
		xfer(1'h0, `PECINT_ADDR_FLAGS, 32'h0);
		seen = q;
		chk("hrdata", 32'h6, seen);
		xfer(1'h0, `PECINT_ADDR_FLAGS, 32'h0);
		xfer(1'h1, `PECINT_ADDR_FLAGS, q & (seen ^ 32'hFF));
		#1 chk("change_irq", 32'h0, {31'h0, change_irq});
		pins.drive(8'h01);
		@(posedge hclk);
		xfer(1'h1, `PECINT_ADDR_FLAGS, 32'h0);
		rc(`PECINT_ADDR_FLAGS, 32'h1);
		$display("t_master end");
	end
	endtask
	task t_sleep;
	begin
		xfer(1'h1, `PECINT_ADDR_FLAGS, 32'h0);
		sleep_mode <= 1'h1;
		@(posedge hclk);
		#1 chk("wake_request", 32'h0, {31'h0, wake_request});
		pins.drive(8'h05);
		repeat (4) @(posedge hclk);
		#1 chk("wake_request", 32'h1, {31'h0, wake_request});
		rc(`PECINT_ADDR_FLAGS, 32'h4);
		sleep_mode <= 1'h0;
		$display("t_sleep end");
	end
	endtask
	task t_irq;
	begin
		xfer(1'h1, `PECINT_ADDR_IRQ_EN, 32'h3);
		#1 chk("irq", 32'h1, {31'h0, irq});
		rc(`PECINT_ADDR_IRQ_STAT, 32'h3);
		xfer(1'h1, `PECINT_ADDR_IRQ_EN, 32'h0);
		#1 chk("irq", 32'h0, {31'h0, irq});
		xfer(1'h1, `PECINT_ADDR_IRQ_CLR, 32'h3);
		rc(`PECINT_ADDR_IRQ_STAT, 32'h0);
		xfer(1'h1, `PECINT_ADDR_IRQ_EN, 32'h1);
		pins.drive(8'h01);
		repeat (5) @(posedge hclk);
		#1 chk("irq", 32'h1, {31'h0, irq});
		$display("t_irq end");
	end
	endtask
	task t_rst2;
	integer a;
	begin
		xfer(1'h1, `PECINT_ADDR_RISE, 32'hFF);
		xfer(1'h1, `PECINT_ADDR_FALL, 32'hFF);
		xfer(1'h1, `PECINT_ADDR_FLAGS, 32'h80);
		rc(`PECINT_ADDR_FLAGS, 32'h80);
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		for (a = 0; a <= 28; a = a + 4)
			rc(a[7:0], 32'h0);
		$display("t_rst2 end");
	end
	endtask
	always @(posedge hclk)
	begin
		cyc = cyc + 1;
		if (cyc > 2000)
		begin
			failures = failures + 1;
			wrap_up;
		end
	end
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset;
		t_edges;
		t_master;
		t_sleep;
		t_irq;
		t_rst2;
		wrap_up;
	end
endmodule
bind pecint_core pecint_props chk_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.watched_port(watched_port), .sleep_mode(sleep_mode),
	.change_irq(change_irq), .wake_request(wake_request), .irq(irq));
